// ==== rtl/ext_pin_int_pkg.sv ====
package ext_pin_int_pkg;

    // register bus geometry
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_PIN_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_INT_STAT = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_INT_CLR  = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_INT_EN   = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_VEC_NUM  = 3'h4;

    // pin control register fields
    localparam int BIT_PULL_DIS = 6;
    localparam int BIT_RSVD     = 5;
    localparam int BIT_FUNC_EN  = 4;
    localparam int BIT_FLAG     = 3;
    localparam int BIT_ACK      = 2;
    localparam int BIT_INT_EN   = 1;
    localparam int BIT_MODE     = 0;

    // block event bits in status, clear and enable registers
    localparam int EVT_PIN   = 0;
    localparam int EVT_RESET = 1;
    localparam int EVT_W     = 2;

    // reset values
    localparam logic             CTRL_BIT_RST = 1'b0;
    localparam logic [EVT_W-1:0] INT_EN_RST   = 2'h0;
    localparam logic [EVT_W-1:0] INT_STAT_RST = 2'h0;

    // vector table
    localparam int          NUM_VEC      = 32;
    localparam int          VEC_W        = 5;
    localparam logic [15:0] VEC_TOP_ADDR = 16'hfffe;
    localparam logic [VEC_W-1:0] VEC_RESET = 5'h00;
    localparam logic [VEC_W-1:0] VEC_SWI   = 5'h01;
    localparam logic [VEC_W-1:0] VEC_PIN   = 5'h02;
    // vectors 3,5,6,7,12..20,23 have peripheral sources
    localparam logic [NUM_VEC-1:0] PERIPH_SRC_MASK = 32'h009f_f0e8;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    // sources sharing the reset vector
    typedef struct packed {
        logic watchdog_timeout;
        logic low_voltage;
        logic reset_pin;
        logic illegal_opcode;
        logic illegal_address;
        logic power_on;
    } reset_src_s;

    // local enables of the gated reset sources
    typedef struct packed {
        logic watchdog_en;
        logic low_voltage_reset_en;
        logic reset_pin_en;
    } reset_en_s;

endpackage

// ==== rtl/pin_sync_detect.sv ====
`timescale 1ns/1ps
`default_nettype none

module pin_sync_detect
    import ext_pin_int_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_n_in,
    input  wire logic func_en_in,
    input  wire logic stop_mode_in,
    output logic      level_high_out,
    output logic      fall_edge_out,
    output logic      wake_out
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic prev_q;
    logic wake_q;
    logic wake_clr;

    // three-stage synchroniser; only s2 reads s1
    always_ff @(posedge clk_in)
    begin
        s1_q <= pin_n_in;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // a level change counts once stages two and three agree, idles high (pulled up)
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            level_q <= 1'b1;
            prev_q  <= 1'b1;
        end
        else
        begin
            if (s2_q == s3_q)
                level_q <= s3_q;
            prev_q <= level_q;
        end
    end

    // wake latch clocked by the pin itself, since no system clock runs in stop;
    // cleared whenever stop is left or the pin function is off
    assign wake_clr = rst_in | ~stop_mode_in | ~func_en_in;

    always_ff @(negedge pin_n_in or posedge wake_clr)
    begin
        if (wake_clr)
            wake_q <= 1'b0;
        else
            wake_q <= 1'b1;
    end

    assign level_high_out = level_q;
    assign fall_edge_out  = prev_q & ~level_q;
    assign wake_out       = wake_q;

endmodule // pin_sync_detect

`default_nettype wire

// ==== rtl/vector_prio_enc.sv ====
`timescale 1ns/1ps
`default_nettype none

module vector_prio_enc
    import ext_pin_int_pkg::*;
#(
    parameter int N = NUM_VEC,
    parameter int W = VEC_W
)
(
    input  wire logic [N-1:0] req_in,
    output logic              found_out,
    output logic [W-1:0]      num_out
);

    logic [N:0]       lower;
    logic [W-1:0]     acc [N+1];

    // the index must fit the number width
    if (N > (1 << W) || N < 2)
    begin : g_bad_size
        $error("vector_prio_enc: N does not fit W");
    end

    assign lower[0] = 1'b0;
    assign acc[0]   = '0;

    // lowest index wins: each entry hits only if no lower one requests
    for (genvar i = 0; i < N; i++)
    begin : g_entry
        logic hit;
        assign hit        = req_in[i] & ~lower[i];
        assign lower[i+1] = lower[i] | req_in[i];
        assign acc[i+1]   = acc[i] | (hit ? W'(i) : '0);
    end

    assign found_out = lower[N];
    assign num_out   = acc[N];

endmodule // vector_prio_enc

`default_nettype wire

// ==== rtl/ext_pin_int_ctrl.sv ====
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ext_pin_int_ctrl
    import ext_pin_int_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [DATA_W-1:0]   reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [DATA_W-1:0]   reg_rdata_out,
    input  wire logic                pin_n_in,
    output logic                     pin_pull_en_out,
    output logic                     pin_level_high_out,
    output logic                     pin_level_valid_out,
    input  wire logic                stop_mode_in,
    output logic                     wake_out,
    input  wire logic [NUM_VEC-1:0]  periph_flag_in,
    input  wire logic [NUM_VEC-1:0]  periph_en_in,
    input  wire logic                software_interrupt_in,
    input  wire reset_src_s          reset_src_in,
    input  wire reset_en_s           reset_en_in,
    input  wire logic                core_imask_in,
    output logic                     core_req_out,
    output logic      [VEC_W-1:0]    vec_num_out,
    output logic      [15:0]         vec_hi_addr_out,
    output logic      [15:0]         vec_lo_addr_out,
    output logic                     irq_out
);

    // control and status state
    logic                pin_pull_disable_q;
    logic                pin_int_function_en_q;
    logic                pin_event_int_en_q;
    logic                pin_detect_mode_q;
    logic                pin_event_flag_q;
    logic                pin_event_flag_d;
    logic [EVT_W-1:0]    int_stat_q;
    logic [EVT_W-1:0]    int_stat_d;
    logic [EVT_W-1:0]    int_en_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                irq_q;
    logic                pull_en_q;
    logic                level_high_q;
    logic                level_valid_q;
    logic                core_req_q;
    logic [VEC_W-1:0]    vec_num_q;
    logic [15:0]         vec_hi_q;
    logic [15:0]         vec_lo_q;

    // detector outputs
    logic                level_high;
    logic                fall_edge;
    logic                wake;

    // the vector table must fit the number width and stay inside the address space
    if (NUM_VEC > (1 << VEC_W) || int'(VEC_TOP_ADDR) < 2 * (NUM_VEC - 1))
    begin : g_bad_table
        $error("ext_pin_int_ctrl: vector table does not fit");
    end

    // the peripheral mask must leave the reset, software and pin vectors alone,
    // otherwise a peripheral flag could pose as one of them
    if ((PERIPH_SRC_MASK & NUM_VEC'(7)) != '0)
    begin : g_bad_mask
        $error("ext_pin_int_ctrl: peripheral mask overlaps fixed vectors");
    end

    // a control write with ack set is the only way software clears the flag

    // bus decode
    wire wr_ctrl   = reg_wr_in & (reg_addr_in == OFS_PIN_CTRL);
    wire wr_clr    = reg_wr_in & (reg_addr_in == OFS_INT_CLR);
    wire wr_en     = reg_wr_in & (reg_addr_in == OFS_INT_EN);
    wire pin_ack   = wr_ctrl & reg_wdata_in[BIT_ACK];

    pin_sync_detect u_pin
    (
        .clk_in         (clk_in),
        .rst_in         (rst_in),
        .pin_n_in       (pin_n_in),
        .func_en_in     (pin_int_function_en_q),
        .stop_mode_in   (stop_mode_in),
        .level_high_out (level_high),
        .fall_edge_out  (fall_edge),
        .wake_out       (wake)
    );

    wire pin_asserted = ~level_high;

    // level mode keeps setting while low
    wire pin_set = pin_int_function_en_q
                   & (fall_edge | (pin_detect_mode_q & pin_asserted));

    // ack clears, but a set in the same cycle wins
    assign pin_event_flag_d = pin_set | (pin_event_flag_q & ~pin_ack);

    // flag forwarded only with local enable
    // disabled enable leaves flag for polling
    wire pin_req = pin_event_flag_q & pin_event_int_en_q;

    // illegal opcode, illegal address and power-on have no enable and always count
    // reset vector sources, three of them gated
    wire reset_req = (reset_src_in.watchdog_timeout & reset_en_in.watchdog_en)
                   | (reset_src_in.low_voltage & reset_en_in.low_voltage_reset_en)
                   | (reset_src_in.reset_pin & reset_en_in.reset_pin_en)
                   | reset_src_in.illegal_opcode
                   | reset_src_in.illegal_address
                   | reset_src_in.power_on;

    // sources placed at their fixed vectors
    // vectors without a source are masked off
    wire [NUM_VEC-1:0] periph_req = periph_flag_in & periph_en_in & PERIPH_SRC_MASK;
    wire [NUM_VEC-1:0] vec_req    = periph_req
                                  | (NUM_VEC'(reset_req) << VEC_RESET)
                                  | (NUM_VEC'(software_interrupt_in) << VEC_SWI)
                                  | (NUM_VEC'(pin_req) << VEC_PIN);

    logic             vec_found;
    logic [VEC_W-1:0] vec_num;

    vector_prio_enc #(
        .N (NUM_VEC),
        .W (VEC_W)
    ) u_prio
    (
        .req_in    (vec_req),
        .found_out (vec_found),
        .num_out   (vec_num)
    );

    // high byte at 0xfffe minus twice the number, low byte next
    wire [15:0] vec_hi_addr = VEC_TOP_ADDR - {10'h000, vec_num, 1'b0};
    wire [15:0] vec_lo_addr = vec_hi_addr + 16'h0001;

    // a stray core mask must never hold off a reset request
    // maskable requests wait for mask 0; the reset vector cannot be masked
    wire core_req_d = vec_found & ((vec_num == VEC_RESET) | ~core_imask_in);

    // block events: sticky, set wins over software clear
    wire [EVT_W-1:0] evt_set;
    assign evt_set[EVT_PIN]   = pin_set;
    assign evt_set[EVT_RESET] = reset_req;
    assign int_stat_d = evt_set
                      | (int_stat_q & ~(wr_clr ? reg_wdata_in[EVT_W-1:0] : '0));

    // control register read layout; bit 5 and ack read as zero
    wire [DATA_W-1:0] ctrl_rd = {1'b0,
                                 pin_pull_disable_q,
                                 1'b0,
                                 pin_int_function_en_q,
                                 pin_event_flag_q,
                                 1'b0,
                                 pin_event_int_en_q,
                                 pin_detect_mode_q};

    // reads have no side effects, so a speculative read is harmless
    // read select; unmapped and write-only offsets read zero
    logic [DATA_W-1:0] rd_sel;
    always_comb
    begin
        unique case (reg_addr_in)
            OFS_PIN_CTRL: rd_sel = ctrl_rd;
            OFS_INT_STAT: rd_sel = DATA_W'(int_stat_q);
            OFS_INT_EN:   rd_sel = DATA_W'(int_en_q);
            OFS_VEC_NUM:  rd_sel = DATA_W'(vec_num_q);
            default:      rd_sel = '0;
        endcase
    end

    // control fields written, reserved bit ignored
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_pull_disable_q    <= CTRL_BIT_RST;
            pin_int_function_en_q <= CTRL_BIT_RST;
            pin_event_int_en_q    <= CTRL_BIT_RST;
            pin_detect_mode_q     <= CTRL_BIT_RST;
        end
        else if (wr_ctrl)
        begin
            pin_pull_disable_q    <= reg_wdata_in[BIT_PULL_DIS];
            pin_int_function_en_q <= reg_wdata_in[BIT_FUNC_EN];
            pin_event_int_en_q    <= reg_wdata_in[BIT_INT_EN];
            pin_detect_mode_q     <= reg_wdata_in[BIT_MODE];
        end
    end

    // irq follows status one cycle late, so a clear and its effect stay ordered
    // flags and block interrupt state
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_event_flag_q <= CTRL_BIT_RST;
            int_stat_q       <= INT_STAT_RST;
            int_en_q         <= INT_EN_RST;
            irq_q            <= 1'b0;
        end
        else
        begin
            pin_event_flag_q <= pin_event_flag_d;
            int_stat_q       <= int_stat_d;
            if (wr_en)
                int_en_q <= reg_wdata_in[EVT_W-1:0];
            irq_q <= |(int_stat_q & int_en_q);
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_q <= '0;
        else
            rdata_q <= reg_rd_in ? rd_sel : '0;
    end

    // the pullup stays off while the function is off so the pin floats for other use
    // pullup active only with the pin function on and not disabled
    // level visible to branch logic only while pin is the request input
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pull_en_q     <= 1'b0;
            level_high_q  <= 1'b1;
            level_valid_q <= 1'b0;
        end
        else
        begin
            pull_en_q     <= pin_int_function_en_q & ~pin_pull_disable_q;
            level_high_q  <= level_high;
            level_valid_q <= pin_int_function_en_q;
        end
    end

    // registering costs a cycle of latency but keeps the core's inputs glitch free
    // vector outputs to the core, one cycle behind the sources
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            core_req_q <= 1'b0;
            vec_num_q  <= VEC_RESET;
            vec_hi_q   <= VEC_TOP_ADDR;
            vec_lo_q   <= VEC_TOP_ADDR + 16'h0001;
        end
        else
        begin
            core_req_q <= core_req_d;
            vec_num_q  <= vec_num;
            vec_hi_q   <= vec_hi_addr;
            vec_lo_q   <= vec_lo_addr;
        end
    end

    assign reg_rdata_out       = rdata_q;
    assign irq_out             = irq_q;
    assign pin_pull_en_out     = pull_en_q;
    assign pin_level_high_out  = level_high_q;
    assign pin_level_valid_out = level_valid_q;
    // the wake latch is not synchronised: it only restarts the clocks,
    // and the clocked path sees the same pin edge once the clock runs
    assign wake_out            = wake;    // flop clocked by the pin
    assign core_req_out        = core_req_q;
    assign vec_num_out         = vec_num_q;
    assign vec_hi_addr_out     = vec_hi_q;
    assign vec_lo_addr_out     = vec_lo_q;

endmodule // ext_pin_int_ctrl

`default_nettype wire

// ==== tb/ext_pin_int_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module ext_pin_int_checker
    import ext_pin_int_pkg::*;
(
    input wire logic               clk_in,
    input wire logic               rst_in,
    input wire logic [ADDR_W-1:0]  reg_addr_in,
    input wire logic               reg_rd_in,
    input wire logic [DATA_W-1:0]  reg_rdata_out,
    input wire logic               pin_pull_en_out,
    input wire logic               pin_level_valid_out,
    input wire logic               stop_mode_in,
    input wire logic               wake_out,
    input wire logic [NUM_VEC-1:0] periph_flag_in,
    input wire logic [NUM_VEC-1:0] periph_en_in,
    input wire reset_src_s         reset_src_in,
    input wire logic               core_imask_in,
    input wire logic               core_req_out,
    input wire logic [VEC_W-1:0]   vec_num_out,
    input wire logic [15:0]        vec_hi_addr_out,
    input wire logic [15:0]        vec_lo_addr_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // ack and reserved bits read 0
    chk_ctrl_rd_zero: assert property (
        $past(reg_rd_in) && $past(reg_addr_in) == OFS_PIN_CTRL
        |-> !reg_rdata_out[7] && !reg_rdata_out[5] && !reg_rdata_out[2])
        else $error("ctrl read shows ack or reserved bit");
    chk_vec_addr: assert property (
        vec_lo_addr_out == vec_hi_addr_out + 16'h1 && vec_hi_addr_out == 16'hfffe - {10'h0, vec_num_out, 1'b0})
        else $error("vector byte address mismatch");
    // pullup only with pin function on
    chk_pull_func: assert property (pin_pull_en_out |-> pin_level_valid_out)
        else $error("pullup on while pin function off");
    chk_wake_stop: assert property (wake_out |-> stop_mode_in)
        else $error("wake outside stop");
    chk_mask_gate: assert property (
        core_req_out && vec_num_out != 5'h00 |-> !$past(core_imask_in))
        else $error("request passed the global mask");
    // peripheral request needs flag and enable
    chk_src_enable: assert property (
        core_req_out && PERIPH_SRC_MASK[vec_num_out]
        |-> ($past(periph_flag_in) & $past(periph_en_in) & (32'h1 << vec_num_out)) != 32'h0)
        else $error("request without flag and enable");
    // no enabled lower peripheral source left waiting
    chk_prio_low: assert property (
        core_req_out |-> ($past(periph_flag_in) & $past(periph_en_in) & PERIPH_SRC_MASK
        & ((32'h1 << vec_num_out) - 32'h1)) == 32'h0)
        else $error("lower vector pending but not chosen");
    chk_reset_vec: assert property (
        $past(reset_src_in.power_on) && !$past(rst_in) |-> core_req_out && vec_num_out == VEC_RESET)
        else $error("reset source missed vector 0");
endmodule // ext_pin_int_checker

bind ext_pin_int_ctrl ext_pin_int_checker i_chk (.*);

`default_nettype wire

// ==== tb/ext_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ext_source_model
    import ext_pin_int_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             pull_low_in,
    input  wire logic             unmask_in,
    input  wire logic             core_req_in,
    input  wire logic [VEC_W-1:0] vec_num_in,
    output logic                  pin_n_out,
    output logic                  imask_out,
    output logic [VEC_W-1:0]      taken_vec_out
);
    // open-drain source: a released pin is pulled high
    initial pin_n_out = 1'b1;
    always @(posedge clk_in)
    begin
        pin_n_out <= !pull_low_in;
    end

    // core takes the vector and sets its mask, no nesting
    initial imask_out = 1'b1;
    initial taken_vec_out = '0;
    always @(posedge clk_in)
    begin
        if (rst_in)
            imask_out <= 1'b1;
        else if (core_req_in && !imask_out)
        begin
            taken_vec_out <= vec_num_in;
            imask_out <= 1'b1;
        end
        else if (unmask_in)
            imask_out <= 1'b0;
    end
endmodule // ext_source_model

`default_nettype wire

// ==== tb/test_ext_pin_interrupt_and_vectoring.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_ext_pin_interrupt_and_vectoring
    import ext_pin_int_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic stop = 1'b0;
    logic software_interrupt = 1'b0;
    logic [NUM_VEC-1:0] pflag = '0;
    logic [NUM_VEC-1:0] pen = '0;
    reset_src_s rsrc = '0;
    reset_en_s ren = '0;
    logic pull_low = 1'b0;
    logic unmask = 1'b0;
    logic pin_n, imask, pull_en, lvl_hi, lvl_ok, wake, req, irq, rd_d;
    logic [DATA_W-1:0] rdata;
    logic [VEC_W-1:0] vnum, taken;
    logic [15:0] vhi, vlo;
    logic [DATA_W-1:0] exp_q[$];
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    ext_pin_int_ctrl i_dut (.clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .pin_n_in(pin_n),
        .pin_pull_en_out(pull_en), .pin_level_high_out(lvl_hi), .pin_level_valid_out(lvl_ok),
        .stop_mode_in(stop), .wake_out(wake), .periph_flag_in(pflag), .periph_en_in(pen),
        .software_interrupt_in(software_interrupt), .reset_src_in(rsrc), .reset_en_in(ren), .core_imask_in(imask),
        .core_req_out(req), .vec_num_out(vnum), .vec_hi_addr_out(vhi), .vec_lo_addr_out(vlo),
        .irq_out(irq));

    ext_source_model i_src (.clk_in(clk), .rst_in(rst), .pull_low_in(pull_low), .unmask_in(unmask),
        .core_req_in(req), .vec_num_in(vnum), .pin_n_out(pin_n), .imask_out(imask),
        .taken_vec_out(taken));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // a hang is cut short well past the expected run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            end_sim();
        end
    end

    // read data stand only in the cycle after the strobe
    initial rd_d = 1'b0;
    always @(posedge clk)
    begin
        if (rd_d)
            check(rdata, exp_q.pop_front());
        rd_d <= rd_s;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        exp_q.push_back(e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
    endtask

    // step past the edge so registered outputs have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial
    begin
        logic [31:0] f, e, m;
        logic [VEC_W-1:0] ev;
        void'($urandom(45946));
        settle(2);
        rst <= 1'b0;
        settle(1);
        check(pull_en, 1'b0);
        check(lvl_ok, 1'b0);
        check(vhi, VEC_TOP_ADDR);
        for (int a = 0; a < 8; a++)
            rd(a[ADDR_W-1:0], 8'h00);
        pull_low <= 1'b1;
        settle(8);
        rd(OFS_PIN_CTRL, 8'h00);
        pull_low <= 1'b0;
        wr(OFS_PIN_CTRL, 8'h32);
        rd(OFS_PIN_CTRL, 8'h12);
        settle(2);
        check(pull_en, 1'b1);
        check(lvl_ok, 1'b1);
        wr(OFS_PIN_CTRL, 8'h52);
        rd(OFS_PIN_CTRL, 8'h52);
        settle(2);
        check(pull_en, 1'b0);
        wr(OFS_PIN_CTRL, 8'h12);
        wr(OFS_INT_EN, 8'h01);
        pull_low <= 1'b1;
        settle(8);
        check(lvl_hi, 1'b0);
        rd(OFS_PIN_CTRL, 8'h1a);
        rd(OFS_INT_STAT, 8'h01);
        rd(OFS_VEC_NUM, 8'h02);
        settle(1);
        check(irq, 1'b1);
        check(req, 1'b0);
        check(vlo, 16'hfffb);
        unmask <= 1'b1;
        settle(3);
        unmask <= 1'b0;
        check(taken, VEC_PIN);
        // ack while still low: edge mode clears and sees no new edge
        wr(OFS_PIN_CTRL, 8'h16);
        rd(OFS_PIN_CTRL, 8'h12);
        wr(OFS_INT_CLR, 8'h01);
        rd(OFS_INT_STAT, 8'h00);
        wr(OFS_PIN_CTRL, 8'h13);
        settle(2);
        rd(OFS_PIN_CTRL, 8'h1b);
        wr(OFS_PIN_CTRL, 8'h17);
        rd(OFS_PIN_CTRL, 8'h1b);
        pull_low <= 1'b0;
        settle(8);
        check(lvl_hi, 1'b1);
        wr(OFS_PIN_CTRL, 8'h17);
        rd(OFS_PIN_CTRL, 8'h13);
        // polling only, then a stop-mode wake
        wr(OFS_PIN_CTRL, 8'h10);
        pull_low <= 1'b1;
        settle(8);
        rd(OFS_PIN_CTRL, 8'h18);
        settle(0);
        check(vnum, VEC_RESET);
        pull_low <= 1'b0;
        settle(5);
        stop <= 1'b1;
        pull_low <= 1'b1;
        settle(2);
        check(wake, 1'b1);
        stop <= 1'b0;
        pull_low <= 1'b0;
        settle(6);
        check(wake, 1'b0);
        wr(OFS_PIN_CTRL, 8'h14);
        rd(OFS_PIN_CTRL, 8'h10);
        wr(OFS_PIN_CTRL, 8'h00);
        wr(OFS_INT_CLR, 8'h03);
        unmask <= 1'b1;
        // sparse random peripheral requests, unused vectors included
        for (int i = 0; i < 24; i++)
        begin
            f = $urandom() & $urandom() & $urandom();
            e = $urandom();
            pflag <= f;
            pen <= e;
            settle(2);
            m = f & e & PERIPH_SRC_MASK;
            ev = '0;
            for (int b = 31; b >= 0; b--)
                if (m[b])
                    ev = b[VEC_W-1:0];
            check(vnum, ev);
        end
        pflag <= '1;
        pen <= '1;
        software_interrupt <= 1'b1;
        settle(2);
        check(vnum, VEC_SWI);
        for (int i = 0; i < 6; i++)
        begin
            rsrc <= 6'h01 << i;
            ren <= '0;
            settle(2);
            check(vnum, (i > 2) ? VEC_SWI : VEC_RESET);
            ren <= '1;
            settle(2);
            check(req, 1'b1);
        end
        rd(OFS_INT_STAT, 8'h02);
        wr(OFS_INT_EN, 8'h02);
        settle(1);
        check(irq, 1'b1);
        rsrc <= '0;
        wr(OFS_INT_CLR, 8'h02);
        rd(OFS_INT_STAT, 8'h00);
        settle(1);
        check(irq, 1'b0);
        end_sim();
    end
endmodule // test_ext_pin_interrupt_and_vectoring

`default_nettype wire
